// ---- src/translation_unit_id_regs.v ----
// Functional notes
// RULE1 - secure and non-secure views give identical id values except view-specific fields.
// RULE2 - stage-one, nested and table-format fields read 1 in a stage-2-only build, else 0.
// RULE3 - page-index field [30:28] encodes the context count as 2 to 6.
// RULE4 - secure view shows table-present as (entries configured) and index width 0xf.
// RULE5 - non-secure view shows table-present and index width as zero.
// RULE6 - monitor registers reset to zero except capability fields, group counter number 4.
// RULE7 - monitor config holds unit count minus one and four times count minus one.
// RULE8 - unassigned offsets are reserved: read zero, writes ignored.
// RULE9 - aux config at 0x10 is read-write with separate secure and non-secure copies.
// RULE10 - secure-only debug pointer/data pairs at 0x80..0x8c.
// RULE11 - writes not aligned to a word are discarded.
// RULE12 - writes to id and capability fields are ignored.
`timescale 1ns/1ps
`default_nettype none
`include "xlat_id_map.vh"

module translation_unit_id_regs #(
    parameter STAGE2_ONLY  = 1,
    parameter NUM_CONTEXTS = 8,
    parameter NUM_SMR      = 8,
    parameter NUM_SSD      = 0,
    parameter NUM_TBU      = 1
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        reg_req,
    input  wire        reg_write,
    input  wire        reg_secure,
    input  wire [15:0] reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire [3:0]  reg_wstrb,
    input  wire [31:0] tbu_lookup_data,
    input  wire [31:0] walk_lookup_data,
    output reg         rsp_valid_q,
    output reg  [31:0] rsp_rdata_q,
    output reg         rsp_err_q,
    output reg  [31:0] aux_config_ns_q,
    output reg  [31:0] aux_config_s_q,
    output wire [31:0] tbu_debug_ptr,
    output wire [31:0] walk_debug_ptr,
    output wire        tbu_debug_read,
    output wire        walk_debug_read,
    output reg  [31:0] monitor_group_config_q
);
    // ======================================================================
    // derived capability constants
    localparam [31:0] GROUPS_I    = NUM_TBU - 1;
    localparam [31:0] COUNTERS_I  = NUM_TBU * 4 - 1;
    localparam [7:0]  GROUPS_M1   = GROUPS_I[7:0];
    localparam [7:0]  COUNTERS_M1 = COUNTERS_I[7:0];
    localparam [31:0] MONITOR_CONFIG_VAL = {GROUPS_M1, 16'h0, COUNTERS_M1}  // RULE7
                                         | `MONITOR_EXPORT_BIT
                                         | ({26'h0, `MONITOR_COUNTER_SIZE}
                                            << `F_MON_COUNTER_SIZE_LO);   // RULE6
    localparam [31:0] GROUP_CONFIG_RESET = {4'h0, `GROUP_COUNTER_NUMBER, 24'h0}; // RULE6

    // ======================================================================
    // request qualification
    wire aligned   = (reg_addr[1:0] == 2'b00);
    wire full_strb = (reg_wstrb == 4'hf);
    wire wr_ok     = reg_req & reg_write & aligned & full_strb;   // RULE11
    wire rd_req    = reg_req & ~reg_write;

    wire hit_aux   = (reg_addr == `OFS_AUX_CONFIG);
    wire hit_tptr  = (reg_addr == `OFS_TBU_DEBUG_PTR);
    wire hit_tdat  = (reg_addr == `OFS_TBU_DEBUG_DATA);
    wire hit_wptr  = (reg_addr == `OFS_WALK_DEBUG_PTR);
    wire hit_wdat  = (reg_addr == `OFS_WALK_DEBUG_DATA);
    wire hit_gcfg  = (reg_addr == `OFS_MONITOR_GROUP_CONFIG);

    // ======================================================================
    // identification words per view
    wire [31:0] id0_s;
    wire [31:0] id1_s;
    wire [31:0] id2_s;
    wire [31:0] id7_s;
    wire [31:0] id0_ns;
    wire [31:0] id1_ns;
    wire [31:0] id2_ns;
    wire [31:0] id7_ns;

    ident_words #(
        .STAGE2_ONLY  (STAGE2_ONLY),
        .NUM_CONTEXTS (NUM_CONTEXTS),
        .NUM_SMR      (NUM_SMR),
        .NUM_SSD      (NUM_SSD)
    ) u_ident_secure (
        .secure_view (1'b1),
        .ident0      (id0_s),
        .ident1      (id1_s),
        .ident2      (id2_s),
        .ident7      (id7_s)
    );

    ident_words #(
        .STAGE2_ONLY  (STAGE2_ONLY),
        .NUM_CONTEXTS (NUM_CONTEXTS),
        .NUM_SMR      (NUM_SMR),
        .NUM_SSD      (NUM_SSD)
    ) u_ident_nonsecure (
        .secure_view (1'b0),
        .ident0      (id0_ns),
        .ident1      (id1_ns),
        .ident2      (id2_ns),
        .ident7      (id7_ns)
    );

    // ======================================================================
    // secure-only debug pairs
    wire [31:0] tbu_data_word;
    wire [31:0] walk_data_word;

    debug_pointer u_tbu_debug (
        .clk               (clk),
        .rst_n             (rst_n),
        .ptr_write         (wr_ok & reg_secure & hit_tptr),   // RULE10
        .data_read         (rd_req & reg_secure & hit_tdat),
        .wdata             (reg_wdata),
        .lookup_data       (tbu_lookup_data),
        .ptr_q             (tbu_debug_ptr),
        .data_word         (tbu_data_word),
        .data_read_pulse_q (tbu_debug_read)
    );

    debug_pointer u_walk_debug (
        .clk               (clk),
        .rst_n             (rst_n),
        .ptr_write         (wr_ok & reg_secure & hit_wptr),   // RULE10
        .data_read         (rd_req & reg_secure & hit_wdat),
        .wdata             (reg_wdata),
        .lookup_data       (walk_lookup_data),
        .ptr_q             (walk_debug_ptr),
        .data_word         (walk_data_word),
        .data_read_pulse_q (walk_debug_read)
    );

    // ======================================================================
    // banked aux config and monitor group config
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aux_config_ns_q        <= `AUX_CONFIG_RESET;
            aux_config_s_q         <= `AUX_CONFIG_RESET;
            monitor_group_config_q <= GROUP_CONFIG_RESET;   // RULE6
        end else begin
            if (wr_ok && hit_aux && reg_secure) begin
                aux_config_s_q <= reg_wdata & `AUX_CONFIG_WMASK;   // RULE9
            end
            if (wr_ok && hit_aux && !reg_secure) begin
                aux_config_ns_q <= reg_wdata & `AUX_CONFIG_WMASK;  // RULE9
            end
            if (wr_ok && hit_gcfg) begin
                // capability field keeps its value
                monitor_group_config_q <= (reg_wdata & `GROUP_CONFIG_WMASK)
                                        | GROUP_CONFIG_RESET;   // RULE12
            end
        end
    end

    // ======================================================================
    // read mux; unknown offsets, and secure-only regs in the non-secure view, read zero
    reg [31:0] rd_word;

    always @* begin
        rd_word = 32'h0;   // RULE8
        case (reg_addr)
            `OFS_IDENT_FEATURES_0:     rd_word = reg_secure ? id0_s : id0_ns;   // RULE1
            `OFS_IDENT_FEATURES_1:     rd_word = reg_secure ? id1_s : id1_ns;   // RULE4 RULE5
            `OFS_IDENT_FEATURES_2:     rd_word = reg_secure ? id2_s : id2_ns;   // RULE1
            `OFS_IDENT_REVISION:       rd_word = reg_secure ? id7_s : id7_ns;   // RULE1
            `OFS_AUX_CONFIG:           rd_word = reg_secure ? aux_config_s_q
                                                            : aux_config_ns_q;  // RULE9
            `OFS_TBU_DEBUG_PTR:        rd_word = reg_secure ? tbu_debug_ptr : 32'h0;
            `OFS_TBU_DEBUG_DATA:       rd_word = reg_secure ? tbu_data_word : 32'h0;
            `OFS_WALK_DEBUG_PTR:       rd_word = reg_secure ? walk_debug_ptr : 32'h0;
            `OFS_WALK_DEBUG_DATA:      rd_word = reg_secure ? walk_data_word : 32'h0;
            `OFS_MONITOR_GROUP_CONFIG: rd_word = monitor_group_config_q;
            `OFS_MONITOR_EVENT_IDS:    rd_word = `MONITOR_EVENT_IDS_VAL;
            `OFS_MONITOR_AUTH_STATE:   rd_word = `MONITOR_AUTH_STATE_VAL;
            `OFS_MONITOR_DEVICE_CLASS: rd_word = `MONITOR_DEVICE_CLASS_VAL;
            `OFS_MONITOR_CONFIG:       rd_word = MONITOR_CONFIG_VAL;   // RULE7
            default:                   rd_word = 32'h0;   // RULE8
        endcase
    end

    // ======================================================================
    // response: one cycle after each request
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 32'h0;
            rsp_err_q   <= 1'b0;
        end else begin
            rsp_valid_q <= reg_req;
            rsp_rdata_q <= rd_req ? rd_word : 32'h0;
            rsp_err_q   <= reg_req & reg_write & ~(aligned & full_strb);   // RULE11
        end
    end
endmodule

`default_nettype wire

// ---- include/xlat_id_map.vh ----
`ifndef XLAT_ID_MAP_VH
`define XLAT_ID_MAP_VH

// ==========================================================================
// register offsets (byte addresses)
`define OFS_IDENT_FEATURES_0      16'h0020
`define OFS_IDENT_FEATURES_1      16'h0024
`define OFS_IDENT_FEATURES_2      16'h0028
`define OFS_IDENT_REVISION        16'h003c
`define OFS_AUX_CONFIG            16'h0010
`define OFS_TBU_DEBUG_PTR         16'h0080
`define OFS_TBU_DEBUG_DATA        16'h0084
`define OFS_WALK_DEBUG_PTR        16'h0088
`define OFS_WALK_DEBUG_DATA       16'h008c
`define OFS_MONITOR_GROUP_CONFIG  16'h0100
`define OFS_MONITOR_EVENT_IDS     16'h0104
`define OFS_MONITOR_AUTH_STATE    16'h0108
`define OFS_MONITOR_DEVICE_CLASS  16'h010c
`define OFS_MONITOR_CONFIG        16'h0110

// ==========================================================================
// field positions
`define F_STAGE_ONE_SUPPORT       30
`define F_NESTED_SUPPORT          28
`define F_TABLE_FORMAT_LO         24
`define F_PAGE_INDEX_LO           28
`define F_SEC_TABLE_PRESENT       12
`define F_SEC_TABLE_IDX_LO        8
`define F_COUNTER_GROUP_LO        24
`define F_MON_COUNTER_SIZE_LO     8

// ==========================================================================
// reset and fixed values
`define IDENT0_FIXED              32'hac013e00
`define IDENT2_FIXED              32'h00005555
`define SEC_TABLE_IDX_WIDTH_S     4'hf
`define GROUP_COUNTER_NUMBER      4'h4
`define GROUP_CONFIG_WMASK        32'h00000fff
`define MONITOR_EVENT_IDS_VAL     32'h00010101
`define MONITOR_AUTH_STATE_VAL    32'h00000080
`define MONITOR_DEVICE_CLASS_VAL  32'h00000056
`define MONITOR_EXPORT_BIT        32'h00010000
`define MONITOR_COUNTER_SIZE      6'h1f
`define AUX_CONFIG_RESET          32'h00000000
`define AUX_CONFIG_WMASK          32'h03ffffff
`define DEBUG_PTR_RESET           32'h00000000

`endif

// ---- src/ident_words.v ----
`timescale 1ns/1ps
`default_nettype none
`include "xlat_id_map.vh"

// ==========================================================================
// configuration-derived identification words for one security view
module ident_words #(
    parameter STAGE2_ONLY  = 1,
    parameter NUM_CONTEXTS = 8,
    parameter NUM_SMR      = 8,
    parameter NUM_SSD      = 0,
    parameter [3:0] REV_MAJOR = 4'h2,   // arbitrary value
    parameter [3:0] REV_MINOR = 4'h1    // arbitrary value
) (
    input  wire        secure_view,
    output wire [31:0] ident0,
    output wire [31:0] ident1,
    output wire [31:0] ident2,
    output wire [31:0] ident7
);
    localparam [0:0] S2 = (STAGE2_ONLY != 0) ? 1'b1 : 1'b0;
    localparam [2:0] PAGE_IDX = (NUM_CONTEXTS <= 8)  ? 3'h2 :
                                (NUM_CONTEXTS <= 16) ? 3'h3 :
                                (NUM_CONTEXTS <= 32) ? 3'h4 :
                                (NUM_CONTEXTS <= 64) ? 3'h5 : 3'h6;
    localparam [31:0] SMR_I = NUM_SMR;
    localparam [31:0] CTX_I = NUM_CONTEXTS;
    localparam [7:0]  SMR_W = SMR_I[7:0];
    localparam [7:0]  CTX_W = CTX_I[7:0];
    localparam [0:0] SSD_P = (NUM_SSD != 0) ? 1'b1 : 1'b0;

    assign ident0 = `IDENT0_FIXED
                  | ({31'h0, S2} << `F_STAGE_ONE_SUPPORT)   // RULE2
                  | ({31'h0, S2} << `F_NESTED_SUPPORT)      // RULE2
                  | ({31'h0, S2} << `F_TABLE_FORMAT_LO)     // RULE2
                  | {24'h0, SMR_W};
    assign ident1 = ({29'h0, PAGE_IDX} << `F_PAGE_INDEX_LO)  // RULE3
                  | ({31'h0, secure_view & SSD_P} << `F_SEC_TABLE_PRESENT) // RULE4 RULE5
                  | ({28'h0, secure_view ? `SEC_TABLE_IDX_WIDTH_S : 4'h0}
                     << `F_SEC_TABLE_IDX_LO)                   // RULE4 RULE5
                  | {24'h0, CTX_W};
    assign ident2 = `IDENT2_FIXED;
    assign ident7 = {24'h0, REV_MAJOR, REV_MINOR};
endmodule

`default_nettype wire

// ---- src/debug_pointer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "xlat_id_map.vh"

// ==========================================================================
// secure-only debug pointer and read-data pair
module debug_pointer (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ptr_write,
    input  wire        data_read,
    input  wire [31:0] wdata,
    input  wire [31:0] lookup_data,
    output reg  [31:0] ptr_q,
    output wire [31:0] data_word,
    output reg         data_read_pulse_q
);
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q             <= `DEBUG_PTR_RESET;
            data_read_pulse_q <= 1'b0;
        end else begin
            if (ptr_write) begin
                ptr_q <= wdata;   // RULE10
            end
            data_read_pulse_q <= data_read;
        end
    end

    assign data_word = lookup_data;   // RULE10
endmodule

`default_nettype wire

// ---- tb/translation_unit_id_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "xlat_id_map.vh"
// ==========================================
// register port checker
module translation_unit_id_regs_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        reg_req,
    input wire logic        reg_write,
    input wire logic        reg_secure,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [3:0]  reg_wstrb,
    input wire logic [31:0] tbu_lookup_data,
    input wire logic [31:0] walk_lookup_data,
    input wire logic        rsp_valid_q,
    input wire logic [31:0] rsp_rdata_q,
    input wire logic        rsp_err_q,
    input wire logic [31:0] aux_config_ns_q,
    input wire logic [31:0] aux_config_s_q,
    input wire logic [31:0] tbu_debug_ptr,
    input wire logic [31:0] walk_debug_ptr,
    input wire logic        tbu_debug_read,
    input wire logic        walk_debug_read,
    input wire logic [31:0] monitor_group_config_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence good_wr(a, s);
        reg_req && reg_write && reg_wstrb == 4'hf && reg_addr == a && reg_secure == s;
    endsequence
    sequence bad_wr;
        reg_req && reg_write && (reg_addr[1:0] != 2'b00 || reg_wstrb != 4'hf);
    endsequence
    sequence sec_rd(a);
        reg_req && !reg_write && reg_secure && reg_addr == a;
    endsequence
    sequence ns_dbg;
        reg_req && !reg_secure && reg_addr[15:4] == 12'h008;
    endsequence
    bad_write_err_a: assert property (bad_wr |=> rsp_valid_q && rsp_err_q)
        else $error("bad write not flagged");
    bad_write_hold_a: assert property (bad_wr |=> $stable(aux_config_ns_q)
        && $stable(aux_config_s_q) && $stable(tbu_debug_ptr) && $stable(monitor_group_config_q))
        else $error("bad write changed a register");
    aux_ns_write_a: assert property (good_wr(16'h0010, 1'b0) |=>
        aux_config_ns_q == ($past(reg_wdata) & 32'h03ffffff) && $stable(aux_config_s_q))
        else $error("non-secure aux copy wrong");
    aux_s_write_a: assert property (good_wr(16'h0010, 1'b1) |=>
        aux_config_s_q == ($past(reg_wdata) & 32'h03ffffff) && $stable(aux_config_ns_q))
        else $error("secure aux copy wrong");
    ns_debug_hidden_a: assert property (ns_dbg |=> rsp_rdata_q == 32'h0
        && !tbu_debug_read && !walk_debug_read && $stable(tbu_debug_ptr)
        && $stable(walk_debug_ptr))
        else $error("debug pair visible to non-secure");
    tbu_data_read_a: assert property (sec_rd(16'h0084) |=>
        tbu_debug_read && rsp_rdata_q == $past(tbu_lookup_data))
        else $error("buffer data read wrong");
    walk_data_read_a: assert property (sec_rd(16'h008c) |=>
        walk_debug_read && rsp_rdata_q == $past(walk_lookup_data))
        else $error("walk data read wrong");
    tbu_ptr_write_a: assert property (good_wr(16'h0080, 1'b1) |=>
        tbu_debug_ptr == $past(reg_wdata)) else $error("buffer pointer not written");
    group_fixed_a: assert property (monitor_group_config_q[31:12] == 20'h04000)
        else $error("group config fixed bits wrong");
    ident_ro_a: assert property (reg_req && reg_write && reg_wstrb == 4'hf
        && reg_addr[15:5] == 11'h001 && reg_addr[1:0] == 2'b00 |=> !rsp_err_q
        && $stable(aux_config_ns_q) && $stable(aux_config_s_q))
        else $error("id write had effect");
endmodule
bind translation_unit_id_regs translation_unit_id_regs_monitor mon_u (.clk(clk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_write(reg_write), .reg_secure(reg_secure), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wstrb(reg_wstrb), .tbu_lookup_data(tbu_lookup_data),
    .walk_lookup_data(walk_lookup_data), .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q),
    .rsp_err_q(rsp_err_q), .aux_config_ns_q(aux_config_ns_q), .aux_config_s_q(aux_config_s_q),
    .tbu_debug_ptr(tbu_debug_ptr), .walk_debug_ptr(walk_debug_ptr),
    .tbu_debug_read(tbu_debug_read), .walk_debug_read(walk_debug_read),
    .monitor_group_config_q(monitor_group_config_q));
`default_nettype wire

// ---- tb/translation_unit_id_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module translation_unit_id_regs_tb;
    localparam int NCTX = 16, NSMR = 8, NSSD = 2, NTBU = 2;
    logic        clk = 1'b0, rst_n = 1'b0, req = 1'b0, wr = 1'b0, sec = 1'b0, w, sec_r;
    logic [15:0] addr = 16'h0, a;
    logic [3:0]  wstrb = 4'h0, st_r;
    logic [31:0] wdata = 32'h0, tlook = 32'h0, wlook = 32'h0, r;
    logic [31:0] aux_ns = 32'h0, aux_s = 32'h0, tptr = 32'h0, wptr = 32'h0, gcfg = 32'h04000000;
    wire         rv, re, trd, wrd;
    wire  [31:0] rd, ans, as, tp, wp, gc;
    int          n_errors = 0, compares = 0, i, k;
    logic [15:0] ofs [16] = '{16'h0020, 16'h0024, 16'h0028, 16'h003c, 16'h0010, 16'h0080,
        16'h0084, 16'h0088, 16'h008c, 16'h0100, 16'h0104, 16'h0108, 16'h010c, 16'h0110,
        16'h0014, 16'h0200};
    always #2.5 clk = ~clk;
    translation_unit_id_regs #(.STAGE2_ONLY(1), .NUM_CONTEXTS(NCTX), .NUM_SMR(NSMR),
        .NUM_SSD(NSSD), .NUM_TBU(NTBU)) dut_u (.clk(clk), .rst_n(rst_n), .reg_req(req),
        .reg_write(wr), .reg_secure(sec), .reg_addr(addr), .reg_wdata(wdata), .reg_wstrb(wstrb),
        .tbu_lookup_data(tlook), .walk_lookup_data(wlook), .rsp_valid_q(rv), .rsp_rdata_q(rd),
        .rsp_err_q(re), .aux_config_ns_q(ans), .aux_config_s_q(as), .tbu_debug_ptr(tp),
        .walk_debug_ptr(wp), .tbu_debug_read(trd), .walk_debug_read(wrd),
        .monitor_group_config_q(gc));
    // ==========================================
    // expectations
    function automatic logic [31:0] exp_rd(input logic s, input logic [15:0] x);
        if (!s && x >= 16'h0080 && x <= 16'h008c) return 32'h0;
        case (x)
            16'h0020: return 32'hac013e00 | 32'h51000000 | NSMR;
            16'h0024: return 32'h30000000 | (s ? 32'h1f00 : 32'h0) | NCTX;
            16'h0028: return 32'h00005555;
            16'h003c: return 32'h00000021;
            16'h0010: return s ? aux_s : aux_ns;
            16'h0080: return tptr;
            16'h0084: return tlook;
            16'h0088: return wptr;
            16'h008c: return wlook;
            16'h0100: return gcfg;
            16'h0104: return 32'h00010101;
            16'h0108: return 32'h00000080;
            16'h010c: return 32'h00000056;
            16'h0110: return {8'(NTBU - 1), 8'h01, 8'h1f, 8'(NTBU * 4 - 1)};
            default:  return 32'h0;
        endcase
    endfunction
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask
    task automatic stop_test;
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ==========================================
    // one access, request held high between calls
    task automatic acc(input logic ww, s, input logic [15:0] x, input logic [31:0] d,
                       input logic [3:0] st);
        logic bad;
        logic [31:0] e;
        tlook = $urandom;
        wlook = $urandom;
        bad = ww && (x[1:0] != 2'b00 || st != 4'hf);
        e = ww ? 32'h0 : exp_rd(s, x);
        req = 1'b1; wr = ww; sec = s; addr = x; wdata = d; wstrb = st;
        @(posedge clk);
        #1;
        chk1(rv, 1'b1);
        chk1(re, bad);
        chk32(rd, e);
        chk1(trd, !ww && s && x == 16'h0084);
        chk1(wrd, !ww && s && x == 16'h008c);
        if (ww && !bad && x == 16'h0010 && s) aux_s = d & 32'h03ffffff;
        if (ww && !bad && x == 16'h0010 && !s) aux_ns = d & 32'h03ffffff;
        if (ww && !bad && x == 16'h0080 && s) tptr = d;
        if (ww && !bad && x == 16'h0088 && s) wptr = d;
        if (ww && !bad && x == 16'h0100) gcfg = (d & 32'h00000fff) | 32'h04000000;
        chk32(ans, aux_ns);
        chk32(as, aux_s);
        chk32(tp, tptr);
        chk32(wp, wptr);
        chk32(gc, gcfg);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("ERROR %0t: run too long", $time);
        stop_test();
    end
    initial begin
        r = $urandom(32'h42b6);
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        chk32(gc, 32'h04000000);
        chk32(ans | as | tp | wp, 32'h0);
        for (k = 0; k < 2; k++) begin
            for (i = 0; i < 16; i++) begin
                acc(1'b0, k[0], ofs[i], 32'h0, 4'h0);
            end
        end
        acc(1'b1, 1'b0, 16'h0010, 32'hffffffff, 4'hf);
        acc(1'b1, 1'b1, 16'h0010, 32'h00000000, 4'hf);
        acc(1'b0, 1'b0, 16'h0010, 32'h0, 4'h0);
        acc(1'b1, 1'b1, 16'h0012, 32'h5a5a5a5a, 4'hf);
        acc(1'b1, 1'b1, 16'h0080, 32'h12345678, 4'h7);
        acc(1'b1, 1'b0, 16'h0080, 32'hdeadbeef, 4'hf);
        acc(1'b1, 1'b1, 16'h0080, 32'hc0ffee11, 4'hf);
        acc(1'b1, 1'b1, 16'h0088, 32'hffffffff, 4'hf);
        acc(1'b0, 1'b1, 16'h008c, 32'h0, 4'h0);
        acc(1'b1, 1'b1, 16'h0024, 32'hffffffff, 4'hf);
        acc(1'b1, 1'b1, 16'h0100, 32'hffffffff, 4'hf);
        acc(1'b1, 1'b0, 16'h0200, 32'hffffffff, 4'hf);
        for (i = 0; i < 200; i++) begin
            w = 1'($urandom_range(1, 0));
            a = ofs[$urandom_range(15, 0)];
            if (w && $urandom_range(5, 0) == 0) a[1:0] = 2'($urandom_range(3, 1));
            sec_r = 1'($urandom_range(1, 0));
            st_r = ($urandom_range(4, 0) == 0) ? 4'h7 : 4'hf;
            acc(w, sec_r, a, $urandom, st_r);
        end
        req = 1'b0;
        @(posedge clk);
        #1 chk1(rv, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
